// *** verilog/dual_clock_deep_fifo.sv ***
// Deep nine-bit FIFO with sampled write and read clocks and an AHB-Lite slave
// How it works
// - Storage holds 65,536 or 131,072 nine-bit words, per selected variant.
// - Enabled write-clock rise stores write data into the buffer.
// - Enabled read-clock rise moves the next stored word onto read data.
// - Active-low output enable decides whether read data is driven.
// - Write and read clocks are independent, any rate from zero to well under half of ref_clk.
// - Standard mode shows a word only after an explicit enabled read.
// - Fall-through mode moves the first word out after three read-clock transitions.
// - Later fall-through words each need read enable low.
// - Mode select level during full reset picks standard or fall-through.
// - Fall-through outputs cascade straight into another FIFO's inputs.
// - Shared flag pair is empty/full or output-valid/space-available by mode.
// - Half-full, almost-empty and almost-full flags work in both modes.
// - Each almost threshold has its own offset register spanning the depth.
// - Serial load and offset select shift one serial bit per write-clock rise.
// - Write enable with offset select loads offsets in parallel from write data.
// - Read enable with offset select reads offsets back on read data.
// - Full reset returns both pointers to the first location.
// - Offset select level at full reset picks 127 parallel or 1,023 serial.
// - After full reset all flags match the mode and default offsets.
// - Partial reset returns both pointers to the first location.
// - Partial reset keeps mode, method and offsets; flags then follow them.
// - Reread request low at read-clock rise rewinds the read pointer.
// - Retransmit keeps writer and settings, briefly flags output as not ready.
// - Almost-full goes low when count exceeds capacity minus full offset.
// - Both resets clear the output data register to zero.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module dual_clock_deep_fifo
   import fifo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic writeClk,
   input wire logic readClk,
   input wire logic writeEnable_n,
   input wire logic readEnable_n,
   input wire logic outputDriveEnable_n,
   input wire logic modeSelectSerialIn,
   input wire logic offsetLoadSelect_n,
   input wire logic serialLoadEnable_n,
   input wire logic fullReset_n,
   input wire logic partialReset_n,
   input wire logic rereadRequest_n,
   input wire logic [8:0] writeDataIn,
   output logic [8:0] readDataOut,
   output logic readDataOe,
   output logic emptyFlag_n,
   output logic fullFlag_n,
   output logic halfFullFlag_n,
   output logic almostEmptyFlag_n,
   output logic almostFullFlag_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Pointer advance with wrap at the active capacity
   function automatic logic [16:0] nextPtr(input logic [16:0] p, input logic [17:0] cap);
      logic [17:0] inc;
      inc = {1'b0, p} + 18'h1;
      nextPtr = (inc == cap) ? 17'h0 : inc[16:0];
   endfunction

   // Nine-bit slice of the offset pair chosen by the readback index
   function automatic logic [8:0] offSlice(input logic [1:0] idx, input logic [16:0] e,
                                           input logic [16:0] f);
      case (idx)
         2'h0: offSlice = e[8:0];
         2'h1: offSlice = {1'b0, e[16:9]};
         2'h2: offSlice = f[8:0];
         default: offSlice = {1'b0, f[16:9]};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [19:0] pinS1_r, pinS2_r, pinS3_r;
   logic [19:0] pinRaw;
   assign pinRaw = {writeClk, readClk, writeEnable_n, readEnable_n, outputDriveEnable_n,
                    modeSelectSerialIn, offsetLoadSelect_n, serialLoadEnable_n,
                    fullReset_n, partialReset_n, rereadRequest_n, writeDataIn};

   // Two flops per pin, third stage holds the level seen before a clock edge
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinS1_r <= PIN_RST;
         pinS2_r <= PIN_RST;
         pinS3_r <= PIN_RST;
      end else begin
         pinS1_r <= pinRaw;
         pinS2_r <= pinS1_r;
         pinS3_r <= pinS2_r;
      end
   end

   logic wrRise, rdRise, rdToggle, fullRst, partRst, anyRst, ldSel;
   // Edges found by sampling, so either link clock may stop or crawl
   assign wrRise = pinS2_r[PIN_WCLK] & ~pinS3_r[PIN_WCLK];
   assign rdRise = pinS2_r[PIN_RCLK] & ~pinS3_r[PIN_RCLK];
   assign rdToggle = pinS2_r[PIN_RCLK] ^ pinS3_r[PIN_RCLK];
   assign fullRst = ~pinS3_r[PIN_MRS];
   assign partRst = ~pinS3_r[PIN_PRS];
   assign anyRst = fullRst | partRst;
   assign ldSel = ~pinS3_r[PIN_LD];

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration and register slave state

   logic ctrlLarge_r, fwftMode_r, serialMethod_r;
   logic [17:0] capNow;
   assign capNow = ctrlLarge_r ? CAP_LARGE : CAP_SMALL;

   // Mode and programming method caught while full reset is held
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fwftMode_r <= 1'b0;
         serialMethod_r <= 1'b0;
      end else if (fullRst) begin
         fwftMode_r <= pinS3_r[PIN_SI];
         serialMethod_r <= pinS3_r[PIN_LD];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Storage, pointers and word count

   logic [8:0] mem [0:MEM_WORDS-1];
   logic [16:0] wrPtr_r, rdPtr_r;
   logic [17:0] count_r, occ;
   logic [8:0] memRd;
   logic full, wrData, rtEvt, stdPop, ftLoad, pop, offRead;
   out_state_t outState_r;
   logic [1:0] ftCnt_r;

   assign memRd = mem[rdPtr_r];
   assign occ = count_r + {17'h0, fwftMode_r && outState_r == OUT_VALID};
   assign full = occ >= capNow;
   assign wrData = wrRise & ~pinS3_r[PIN_WEN] & ~ldSel & ~full & ~anyRst;
   assign rtEvt = rdRise & ~pinS3_r[PIN_RT] & ~anyRst;
   assign offRead = rdRise & ~pinS3_r[PIN_REN] & ldSel & ~anyRst & ~rtEvt;
   assign stdPop = !fwftMode_r && rdRise && !pinS3_r[PIN_REN] && !ldSel && !anyRst
                   && !rtEvt && count_r != 18'h0;
   assign ftLoad = fwftMode_r && !anyRst && !rtEvt && count_r != 18'h0
                   && ((outState_r == OUT_FILL && ftCnt_r == FT_LAST && rdToggle)
                   || (outState_r == OUT_VALID && rdRise && !pinS3_r[PIN_REN]
                   && !ldSel));
   assign pop = stdPop | ftLoad;

   // Memory write port
   always_ff @(posedge ref_clk) begin
      if (wrData) begin
         mem[wrPtr_r] <= pinS3_r[8:0];
      end
   end

   // Write pointer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_r <= 17'h0;
      end else if (anyRst) begin
         wrPtr_r <= 17'h0;
      end else if (wrData) begin
         wrPtr_r <= nextPtr(wrPtr_r, capNow);
      end
   end

   // Read pointer, rewound by retransmit
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdPtr_r <= 17'h0;
      end else if (anyRst || rtEvt) begin
         rdPtr_r <= 17'h0;
      end else if (pop) begin
         rdPtr_r <= nextPtr(rdPtr_r, capNow);
      end
   end

   // Words held in memory, not counting a fall-through output word
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_r <= 18'h0;
      end else if (anyRst) begin
         count_r <= 18'h0;
      end else if (rtEvt) begin
         count_r <= {1'b0, wrPtr_r} + {17'h0, wrData};
      end else begin
         count_r <= count_r + {17'h0, wrData} - {17'h0, pop};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fall-through output stage

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         outState_r <= OUT_EMPTY;
         ftCnt_r <= 2'h0;
      end else if (anyRst || rtEvt || !fwftMode_r) begin
         outState_r <= OUT_EMPTY;
         ftCnt_r <= 2'h0;
      end else begin
         case (outState_r)
            OUT_EMPTY: begin
               ftCnt_r <= 2'h0;
               if (count_r != 18'h0) begin
                  outState_r <= OUT_FILL;
               end
            end
            OUT_FILL: begin
               if (ftLoad) begin
                  outState_r <= OUT_VALID;
               end else if (rdToggle) begin
                  ftCnt_r <= ftCnt_r + 2'h1;
               end
            end
            OUT_VALID: begin
               if (rdRise && !pinS3_r[PIN_REN] && !ldSel && count_r == 18'h0) begin
                  outState_r <= OUT_EMPTY;
               end
            end
            default: outState_r <= OUT_EMPTY;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Offset registers

   logic [16:0] emptyOff_r, fullOff_r;
   logic [1:0] ldIdx_r, rbIdx_r;
   logic [33:0] offChain;
   logic serShift, parLoad;
   assign offChain = {pinS3_r[PIN_SI], fullOff_r, emptyOff_r[16:1]};
   assign serShift = wrRise & ~pinS3_r[PIN_SEN] & ldSel & serialMethod_r & ~anyRst;
   assign parLoad = wrRise & ~pinS3_r[PIN_WEN] & ldSel & ~serialMethod_r & ~anyRst;

   // Defaults at full reset, kept through partial reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         emptyOff_r <= OFF_DEF_PAR;
         fullOff_r <= OFF_DEF_PAR;
      end else if (fullRst) begin
         emptyOff_r <= pinS3_r[PIN_LD] ? OFF_DEF_SER : OFF_DEF_PAR;
         fullOff_r <= pinS3_r[PIN_LD] ? OFF_DEF_SER : OFF_DEF_PAR;
      end else if (serShift) begin
         fullOff_r <= offChain[33:17];
         emptyOff_r <= offChain[16:0];
      end else if (parLoad) begin
         case (ldIdx_r)
            2'h0: emptyOff_r[8:0] <= pinS3_r[8:0];
            2'h1: emptyOff_r[16:9] <= pinS3_r[7:0];
            2'h2: fullOff_r[8:0] <= pinS3_r[8:0];
            default: fullOff_r[16:9] <= pinS3_r[7:0];
         endcase
      end
   end

   // Parallel load and readback step through the four offset slices
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ldIdx_r <= 2'h0;
         rbIdx_r <= 2'h0;
      end else if (anyRst) begin
         ldIdx_r <= 2'h0;
         rbIdx_r <= 2'h0;
      end else begin
         if (parLoad) begin
            ldIdx_r <= (ldIdx_r == IDX_LAST) ? 2'h0 : ldIdx_r + 2'h1;
         end
         if (offRead) begin
            rbIdx_r <= (rbIdx_r == IDX_LAST) ? 2'h0 : rbIdx_r + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output data register and drive

   logic [8:0] readData_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         readData_r <= 9'h000;
      end else if (anyRst) begin
         readData_r <= 9'h000;
      end else if (offRead) begin
         readData_r <= offSlice(rbIdx_r, emptyOff_r, fullOff_r);
      end else if (pop) begin
         readData_r <= memRd;
      end
   end

   assign readDataOut = readData_r;
   assign readDataOe = ~pinS3_r[PIN_OE];

   ////////////////////////////////////////////////////////////////////////////////
   // Flags

   logic rtHold_r;
   // Output marked not ready from retransmit until the next read-clock rise
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rtHold_r <= 1'b0;
      end else if (anyRst) begin
         rtHold_r <= 1'b0;
      end else if (rtEvt) begin
         rtHold_r <= 1'b1;
      end else if (rdRise) begin
         rtHold_r <= 1'b0;
      end
   end

   logic validOut;
   assign validOut = outState_r == OUT_VALID;

   // Registered flags recomputed every cycle from mode, count and offsets
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         emptyFlag_n <= 1'b0;
         fullFlag_n <= 1'b1;
         halfFullFlag_n <= 1'b1;
         almostEmptyFlag_n <= 1'b0;
         almostFullFlag_n <= 1'b1;
      end else begin
         if (fwftMode_r) begin
            emptyFlag_n <= rtHold_r | ~validOut;
            fullFlag_n <= full;
         end else begin
            emptyFlag_n <= ~rtHold_r & (count_r != 18'h0);
            fullFlag_n <= ~full;
         end
         halfFullFlag_n <= ~(occ > {1'b0, capNow[17:1]});
         almostEmptyFlag_n <= ~(occ <= {1'b0, emptyOff_r});
         almostFullFlag_n <= ~(occ > capNow - {1'b0, fullOff_r});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite register slave, zero wait states

   logic wrPend_r;
   logic [11:0] wrAddr_r;
   logic addrPhase;
   logic [31:0] statusWord;
   assign addrPhase = hsel & hready & htrans[1];
   assign statusWord = {7'h0, serialMethod_r, fwftMode_r, ~almostFullFlag_n,
                        ~almostEmptyFlag_n, ~halfFullFlag_n, full, count_r == 18'h0,
                        occ};

   // Address phase capture and read data
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 12'h000;
         hrdata <= 32'h0;
      end else begin
         wrPend_r <= addrPhase & hwrite;
         if (addrPhase) begin
            wrAddr_r <= haddr[11:0];
         end
         if (addrPhase && !hwrite) begin
            if (haddr[11:0] == ADDR_CTRL) begin
               hrdata <= {31'h0, ctrlLarge_r};
            end else if (haddr[11:0] == ADDR_STATUS) begin
               hrdata <= statusWord;
            end else if (haddr[11:0] == ADDR_EMPTY_OFF) begin
               hrdata <= {15'h0, emptyOff_r};
            end else if (haddr[11:0] == ADDR_FULL_OFF) begin
               hrdata <= {15'h0, fullOff_r};
            end else begin
               hrdata <= 32'h0;
            end
         end
      end
   end

   // Control write in the data phase selects the capacity variant
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlLarge_r <= CTRL_LARGE_RST;
      end else if (wrPend_r && wrAddr_r == ADDR_CTRL) begin
         ctrlLarge_r <= hwdata[CTRL_LARGE_BIT];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   full_reset_ptrs_a: assert property (fullRst |=> wrPtr_r == 17'h0 && rdPtr_r == 17'h0)
      else $error("pointers not cleared by full reset");

   part_reset_ptrs_a: assert property (partRst |=> wrPtr_r == 17'h0
      && rdPtr_r == 17'h0 && count_r == 18'h0)
      else $error("pointers not cleared by partial reset");

   part_reset_keeps_a: assert property (partRst && !fullRst |=> $stable(emptyOff_r)
      && $stable(fullOff_r) && $stable(fwftMode_r) && $stable(serialMethod_r))
      else $error("partial reset disturbed settings");

   out_reg_clear_a: assert property (anyRst |=> readData_r == 9'h000)
      else $error("output register not cleared by reset");

   write_count_a: assert property (wrData && !pop && !rtEvt
      |=> count_r == $past(count_r) + 18'h1)
      else $error("write did not add a word");

   std_read_data_a: assert property (stdPop |=> readData_r == $past(memRd))
      else $error("standard read returned wrong word");

   std_no_fall_a: assert property (!fwftMode_r && !stdPop && !offRead && !anyRst
      |=> $stable(readData_r))
      else $error("standard mode output changed without a read");

   fall_through_mode_fall_a: assert property (fwftMode_r && outState_r == OUT_FILL && ftLoad
      |=> outState_r == OUT_VALID ##1 (!emptyFlag_n || rtHold_r))
      else $error("fall-through word not presented");

   retx_rewind_a: assert property (rtEvt && !wrData && !serShift && !parLoad
      |=> rdPtr_r == 17'h0 && $stable(wrPtr_r) && $stable(emptyOff_r))
      else $error("retransmit mishandled pointers");

   mode_hold_a: assert property (!fullRst |=> $stable(fwftMode_r))
      else $error("mode changed outside full reset");

   readback_a: assert property (offRead && rbIdx_r == 2'h0
      |=> readData_r == $past(emptyOff_r[8:0]))
      else $error("offset readback wrong");

endmodule

// *** verilog/fifo_pkg.sv ***
// Constants shared by the deep nine-bit FIFO and its register slave
package fifo_pkg;
   localparam int unsigned WORD_W = 9;
   localparam int unsigned PTR_W = 17;
   localparam int unsigned CNT_W = 18;
   localparam int unsigned OFF_W = 17;
   localparam int unsigned PIN_W = 20;
   // Capacity of the two storage variants
   localparam logic [17:0] CAP_SMALL = 18'h10000;
   localparam logic [17:0] CAP_LARGE = 18'h20000;
   localparam int unsigned MEM_WORDS = 131072;
   // Default flag offsets picked at full reset
   localparam logic [16:0] OFF_DEF_PAR = 17'h0007f;
   localparam logic [16:0] OFF_DEF_SER = 17'h003ff;
   // Fall-through delay in read-clock transitions, counted from zero
   localparam logic [1:0] FT_LAST = 2'h2;
   localparam logic [1:0] IDX_LAST = 2'h3;
   // Bit positions inside the synchronised pin vector
   localparam int unsigned PIN_WCLK = 19;
   localparam int unsigned PIN_RCLK = 18;
   localparam int unsigned PIN_WEN = 17;
   localparam int unsigned PIN_REN = 16;
   localparam int unsigned PIN_OE = 15;
   localparam int unsigned PIN_SI = 14;
   localparam int unsigned PIN_LD = 13;
   localparam int unsigned PIN_SEN = 12;
   localparam int unsigned PIN_MRS = 11;
   localparam int unsigned PIN_PRS = 10;
   localparam int unsigned PIN_RT = 9;
   // Controls idle, clocks high, full reset held until sampled
   localparam logic [19:0] PIN_RST = 20'hfb600;
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_EMPTY_OFF = 12'h008;
   localparam logic [11:0] ADDR_FULL_OFF = 12'h00c;
   localparam int unsigned CTRL_LARGE_BIT = 0;
   localparam logic CTRL_LARGE_RST = 1'b0;
   // Status register field positions
   localparam int unsigned ST_EMPTY_BIT = 18;
   localparam int unsigned ST_FULL_BIT = 19;
   localparam int unsigned ST_HALF_BIT = 20;
   localparam int unsigned ST_AEMPTY_BIT = 21;
   localparam int unsigned ST_AFULL_BIT = 22;
   localparam int unsigned ST_FALL_THROUGH_MODE_BIT = 23;
   localparam int unsigned ST_SERIAL_BIT = 24;
   // Fall-through output stage
   typedef enum logic [2:0] {
      OUT_EMPTY = 3'b001,
      OUT_FILL = 3'b010,
      OUT_VALID = 3'b100
   } out_state_t;
endpackage

// *** dv/link_partner.sv ***
// Producer and consumer model driving the FIFO link pins
`timescale 1ns/1ps
module link_partner (
   output logic writeClk = 1'b0,
   output logic readClk = 1'b0,
   output logic writeEnable_n = 1'b1,
   output logic readEnable_n = 1'b1,
   output logic offsetLoadSelect_n = 1'b1,
   output logic serialLoadEnable_n = 1'b1,
   output logic modeSelectSerialIn = 1'b0,
   output logic rereadRequest_n = 1'b1,
   output logic [8:0] writeDataIn = 9'h155
);
   event got;
   ////////////////////////////////////////////////////////////////
   // One write-clock frame of 187.5 ns, clock still outside it
   task automatic pulseW;
      #62.5 writeClk = 1'b1;
      #62.5 writeClk = 1'b0;
      #62.5;
   endtask
   // Word or parallel offset slice write
   task automatic wr(input logic [8:0] d, input logic ldN);
      writeDataIn = d;
      writeEnable_n = 1'b0;
      offsetLoadSelect_n = ldN;
      pulseW();
      writeEnable_n = 1'b1;
      offsetLoadSelect_n = 1'b1;
      writeDataIn = ~d;
   endtask
   // Serial offset bit shift
   task automatic sh(input logic b);
      modeSelectSerialIn = b;
      serialLoadEnable_n = 1'b0;
      offsetLoadSelect_n = 1'b0;
      pulseW();
      serialLoadEnable_n = 1'b1;
      offsetLoadSelect_n = 1'b1;
      modeSelectSerialIn = ~b;
   endtask
   // Read frame, offset readback or retransmit
   task automatic rd(input logic renN, input logic ldN, input logic rtN, input bit note);
      readEnable_n = renN;
      offsetLoadSelect_n = ldN;
      rereadRequest_n = rtN;
      #62.5 readClk = 1'b1;
      #62.5 readClk = 1'b0;
      readEnable_n = 1'b1;
      offsetLoadSelect_n = 1'b1;
      rereadRequest_n = 1'b1;
      #62.5;
      if (note) ->got;
   endtask
endmodule

// *** dv/test_dual_clock_deep_fifo.sv ***
// Self-checking bench for the deep dual-clock FIFO
`timescale 1ns/1ps
module test_dual_clock_deep_fifo;
   import fifo_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic fullReset_n = 1'b0, partialReset_n = 1'b1, outputDriveEnable_n = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, readDataOe, emptyFlag_n, fullFlag_n;
   logic halfFullFlag_n, almostEmptyFlag_n, almostFullFlag_n;
   logic [8:0] readDataOut, writeDataIn;
   logic [8:0] w[6];
   logic [8:0] expQ[$];
   logic writeClk, readClk, writeEnable_n, readEnable_n, offsetLoadSelect_n;
   logic serialLoadEnable_n, modeSelectSerialIn, rereadRequest_n;
   int miscompares = 0, comparisons = 0, seed = 58466;
   logic [33:0] offs = {17'h003ff, 17'h00005};
   always #5 ref_clk = ~ref_clk;
   link_partner p_i (.writeClk(writeClk), .readClk(readClk), .writeEnable_n(writeEnable_n),
      .readEnable_n(readEnable_n), .offsetLoadSelect_n(offsetLoadSelect_n),
      .serialLoadEnable_n(serialLoadEnable_n), .modeSelectSerialIn(modeSelectSerialIn),
      .rereadRequest_n(rereadRequest_n), .writeDataIn(writeDataIn));
   dual_clock_deep_fifo dual_clock_deep_fifo_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .writeClk(writeClk), .readClk(readClk), .writeEnable_n(writeEnable_n),
      .readEnable_n(readEnable_n), .outputDriveEnable_n(outputDriveEnable_n),
      .modeSelectSerialIn(modeSelectSerialIn), .offsetLoadSelect_n(offsetLoadSelect_n),
      .serialLoadEnable_n(serialLoadEnable_n), .fullReset_n(fullReset_n),
      .partialReset_n(partialReset_n), .rereadRequest_n(rereadRequest_n),
      .writeDataIn(writeDataIn), .readDataOut(readDataOut), .readDataOe(readDataOe),
      .emptyFlag_n(emptyFlag_n), .fullFlag_n(fullFlag_n), .halfFullFlag_n(halfFullFlag_n),
      .almostEmptyFlag_n(almostEmptyFlag_n), .almostFullFlag_n(almostFullFlag_n));
   ////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Compare seen against expected
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", n, exp, seen);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic waitRdy;
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         miscompares++;
         test_done();
      end
   endtask
   // Single AHB-Lite word transfer
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      r = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
   endtask
   // Full or partial reset pulse
   task automatic rst(input bit full);
      if (full) fullReset_n <= 1'b0;
      else partialReset_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      fullReset_n <= 1'b1;
      partialReset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   // Output word scoreboard
   always @(p_i.got) begin
      if (expQ.size() == 0) chk("unexpected word", 32'(readDataOut), 32'h1000);
      else chk("readDataOut", 32'(readDataOut), 32'(expQ.pop_front()));
   end
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      rst(1);
      chk("flags", 32'({emptyFlag_n, fullFlag_n, halfFullFlag_n, almostEmptyFlag_n,
         almostFullFlag_n}), 32'h0d);
      ahb(0, ADDR_STATUS, 0);
      chk("mode", 32'(r[24:23]), 32'h2);
      ahb(0, ADDR_FULL_OFF, 0);
      chk("fullOff", r, 32'h3ff);
      ahb(0, ADDR_CTRL, 0);
      chk("ctrl", r, 32'h0);
      ahb(1, ADDR_CTRL, 32'h1);
      ahb(0, ADDR_CTRL, 0);
      chk("ctrlLarge", r, 32'h1);
      ahb(1, ADDR_CTRL, 32'h0);
      ahb(1, 12'h0f0, 32'h5a5);
      ahb(0, 12'h0f0, 0);
      chk("unmapped", r, 32'h0);
      for (int i = 0; i < 34; i++) p_i.sh(offs[i]);
      ahb(0, ADDR_EMPTY_OFF, 0);
      chk("emptyOff", r, 32'h5);
      for (int i = 0; i < 6; i++) begin
         w[i] = 9'($random(seed));
         p_i.wr(w[i], 1'b1);
         if (i == 4) chk("aEmpty", 32'(almostEmptyFlag_n), 32'h0);
      end
      chk("aEmpty", 32'(almostEmptyFlag_n), 32'h1);
      chk("noRead", 32'({emptyFlag_n, readDataOut}), 32'h200);
      for (int i = 0; i < 6; i++) begin
         expQ.push_back(w[i]);
         p_i.rd(1'b0, 1'b1, 1'b1, 1);
      end
      expQ.push_back(9'h005);
      p_i.rd(1'b0, 1'b0, 1'b1, 1);
      p_i.rd(1'b1, 1'b1, 1'b0, 0);
      chk("rtEmpty", 32'(emptyFlag_n), 32'h0);
      expQ.push_back(w[0]);
      p_i.rd(1'b0, 1'b1, 1'b1, 1);
      rst(0);
      chk("prs", 32'({emptyFlag_n, readDataOut}), 32'h0);
      ahb(0, ADDR_EMPTY_OFF, 0);
      chk("prsOff", r, 32'h5);
      outputDriveEnable_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("oeOff", 32'(readDataOe), 32'h0);
      outputDriveEnable_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("oeOn", 32'(readDataOe), 32'h1);
      p_i.modeSelectSerialIn <= 1'b1;
      p_i.offsetLoadSelect_n <= 1'b0;
      rst(1);
      p_i.offsetLoadSelect_n <= 1'b1;
      ahb(0, ADDR_EMPTY_OFF, 0);
      chk("parDef", r, 32'h7f);
      chk("ftFlags", 32'({emptyFlag_n, fullFlag_n}), 32'h2);
      p_i.wr(9'h002, 1'b0);
      p_i.wr(9'h000, 1'b0);
      p_i.wr(9'h1fd, 1'b0);
      p_i.wr(9'h07f, 1'b0);
      ahb(0, ADDR_FULL_OFF, 0);
      chk("parLoad", r, 32'h0fffd);
      for (int i = 0; i < 4; i++) begin
         w[i] = 9'($random(seed));
         p_i.wr(w[i], 1'b1);
         if (i == 2) chk("aFull", 32'(almostFullFlag_n), 32'h1);
      end
      chk("aFull", 32'(almostFullFlag_n), 32'h0);
      p_i.rd(1'b1, 1'b1, 1'b1, 0);
      p_i.rd(1'b1, 1'b1, 1'b1, 0);
      chk("fallThru", 32'({emptyFlag_n, readDataOut}), 32'(w[0]));
      chk("aFull", 32'({almostFullFlag_n, almostEmptyFlag_n}), 32'h1);
      for (int i = 1; i < 4; i++) begin
         expQ.push_back(w[i]);
         p_i.rd(1'b0, 1'b1, 1'b1, 1);
      end
      // Let the scoreboard take the last note first
      repeat (2) @(posedge ref_clk);
      chk("left", 32'(expQ.size()), 32'h0);
      test_done();
   end
endmodule
